/* File: src/ocfs_pkg.sv */
package ocfs_pkg;

   // ==========================================================
   // clock and bus
   // ==========================================================
   localparam int unsigned MCLK_PERIOD_NS = 100;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   localparam logic [ADDR_W-1:0] CFG_OFFSET = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;

   // ==========================================================
   // configuration register layout
   // ==========================================================
   localparam int unsigned CFG_W = 8;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h8A;
   localparam int unsigned SIX_LSB = 4;
   localparam int unsigned FIVE_LSB = 0;
   localparam int unsigned SEL_W = 4;

   // status bits
   localparam int unsigned STAT_FIVE_ON = 0;
   localparam int unsigned STAT_SIX_ON = 1;
   localparam int unsigned STAT_FIVE_LVL = 2;
   localparam int unsigned STAT_SIX_LVL = 3;

   // ==========================================================
   // sync rates: period in ns, half period in mclk cycles
   // ==========================================================
   localparam int unsigned SYNC2K_PERIOD_NS = 500000;
   localparam int unsigned SYNC8K_PERIOD_NS = 125000;
   localparam int unsigned SYNC2K_HALF_CYC = SYNC2K_PERIOD_NS / (2 * MCLK_PERIOD_NS);
   localparam int unsigned SYNC8K_HALF_CYC = SYNC8K_PERIOD_NS / (2 * MCLK_PERIOD_NS);
   localparam int unsigned SYNC_CNT_W = 12;

   // half divisor of a pll divided output, in source edges
   localparam int unsigned HALF_W = 5;

   typedef enum logic [SEL_W-1:0] {
      SEL_OFF        = 4'b0000,
      SEL_2K         = 4'b0001,
      SEL_8K         = 4'b0010,
      SEL_MAIN_DIV2  = 4'b0011,
      SEL_DIGITAL    = 4'b0100,
      SEL_MAIN_DIV48 = 4'b0101,
      SEL_MAIN_DIV16 = 4'b0110,
      SEL_MAIN_DIV12 = 4'b0111,
      SEL_MAIN_DIV8  = 4'b1000,
      SEL_MAIN_DIV6  = 4'b1001,
      SEL_MAIN_DIV4  = 4'b1010,
      SEL_SEC_DIV48  = 4'b1011,
      SEL_SEC_DIV16  = 4'b1100,
      SEL_SEC_DIV12  = 4'b1101,
      SEL_SEC_DIV8   = 4'b1110,
      SEL_SEC_DIV4   = 4'b1111
   } ocfs_sel_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
      logic [3:0] byteenable;
   } ocfs_bus_req_t;

endpackage

/* File: src/ocfs_out_sel.sv */
`timescale 1ns/1ps
module ocfs_out_sel (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [ocfs_pkg::SEL_W-1:0] sel,
   input wire logic sync_2k,
   input wire logic sync_8k,
   input wire logic digital_rate_one,
   input wire logic main_edge,
   input wire logic sec_edge,
   output logic clk_out
);
   import ocfs_pkg::*;

   // ==========================================================
   // divider table
   // ==========================================================
   function automatic logic [HALF_W-1:0] half_div(input logic [SEL_W-1:0] s);
      case (ocfs_sel_t'(s))
         SEL_MAIN_DIV2: half_div = 5'h01;
         SEL_MAIN_DIV48, SEL_SEC_DIV48: half_div = 5'h18;
         SEL_MAIN_DIV16, SEL_SEC_DIV16: half_div = 5'h08;
         SEL_MAIN_DIV12, SEL_SEC_DIV12: half_div = 5'h06;
         SEL_MAIN_DIV8, SEL_SEC_DIV8: half_div = 5'h04;
         SEL_MAIN_DIV6: half_div = 5'h03;
         SEL_MAIN_DIV4, SEL_SEC_DIV4: half_div = 5'h02;
         default: half_div = 5'h00;
      endcase
   endfunction

   function automatic logic from_main(input logic [SEL_W-1:0] s);
      from_main = (s >= SEL_MAIN_DIV2) && (s <= SEL_MAIN_DIV4) && (s != SEL_DIGITAL);
   endfunction

   logic [SEL_W-1:0] sel_ff;
   logic [HALF_W-1:0] cnt_ff;
   logic [HALF_W-1:0] nxt_cnt;
   logic div_ff;
   logic nxt_div;
   logic clk_out_ff;
   logic nxt_clk_out;
   logic src_edge;
   logic [HALF_W-1:0] half;

   assign half = half_div(sel);
   assign src_edge = from_main(sel) ? main_edge : sec_edge;

   // ==========================================================
   // pll edge divider
   // ==========================================================
   // pll divided outputs
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_div = div_ff;
      // restart on a new code so a changed divisor never runs past its terminal count
      if (sel != sel_ff) begin
         nxt_cnt = '0;
         nxt_div = 1'b0;
      end else if ((half != 5'h00) && src_edge) begin
         if (cnt_ff == half - 5'h01) begin
            nxt_cnt = '0;
            nxt_div = ~div_ff;
         end else begin
            nxt_cnt = cnt_ff + 5'h01;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sel_ff <= SEL_OFF;
         cnt_ff <= '0;
         div_ff <= 1'b0;
      end else begin
         sel_ff <= sel;
         cnt_ff <= nxt_cnt;
         div_ff <= nxt_div;
      end
   end

   // ==========================================================
   // output mux
   // ==========================================================
   // off, 2k, 8k and digital codes; every other code takes the divider
   always_comb begin
      case (ocfs_sel_t'(sel))
         SEL_OFF: nxt_clk_out = 1'b0;
         SEL_2K: nxt_clk_out = sync_2k;
         SEL_8K: nxt_clk_out = sync_8k;
         SEL_DIGITAL: nxt_clk_out = digital_rate_one;
         default: nxt_clk_out = div_ff;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         clk_out_ff <= 1'b0;
      end else begin
         clk_out_ff <= nxt_clk_out;
      end
   end

   assign clk_out = clk_out_ff;

endmodule

/* File: src/ocfs_freq_select.sv */
// Contract
// - bits 7:4 select the frequency of timing output six.
// - bits 3:0 select the frequency of timing output five.
// - code 0 disables, 1 gives 2 kHz, 2 gives 8 kHz.
// - most other codes give a divided main or secondary pll clock.
// - software writes the register to enable and pick both frequencies.
`timescale 1ns/1ps
module ocfs_freq_select (
   input wire logic mclk,
   input wire logic rst_b,
   input wire ocfs_pkg::ocfs_bus_req_t bus_req,
   output logic [ocfs_pkg::DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire logic main_output_analog_pll,
   input wire logic secondary_analog_pll,
   input wire logic digital_rate_one,
   output logic timing_output_five,
   output logic timing_output_six
);
   import ocfs_pkg::*;

   // ==========================================================
   // input synchronisers
   // ==========================================================
   logic [2:0] main_sync_ff;
   logic [2:0] sec_sync_ff;
   logic [1:0] dig_sync_ff;
   logic main_edge;
   logic sec_edge;

   // stages 0 and 1 settle the pin; stage 2 only remembers the last level
   function automatic logic rise_of(input logic [2:0] s);
      rise_of = s[1] & ~s[2];
   endfunction

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         main_sync_ff <= '0;
      end else begin
         main_sync_ff <= {main_sync_ff[1:0], main_output_analog_pll};
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sec_sync_ff <= '0;
      end else begin
         sec_sync_ff <= {sec_sync_ff[1:0], secondary_analog_pll};
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dig_sync_ff <= '0;
      end else begin
         dig_sync_ff <= {dig_sync_ff[0], digital_rate_one};
      end
   end

   // only stages 1 and 2 feed the edge detect; the pll must run below mclk/2
   assign main_edge = rise_of(main_sync_ff);
   assign sec_edge = rise_of(sec_sync_ff);

   // ==========================================================
   // 2 kHz and 8 kHz sync rates
   // ==========================================================
   logic [SYNC_CNT_W-1:0] cnt2k_ff;
   logic [SYNC_CNT_W-1:0] cnt8k_ff;
   logic sync_2k_ff;
   logic sync_8k_ff;
   logic wrap_2k;
   logic wrap_8k;

   function automatic logic at_wrap(input logic [SYNC_CNT_W-1:0] cnt, input int unsigned half_cyc);
      at_wrap = (cnt == SYNC_CNT_W'(half_cyc - 1));
   endfunction

   // free running from reset; both outputs share them, so they stay in phase
   assign wrap_2k = at_wrap(cnt2k_ff, SYNC2K_HALF_CYC);
   assign wrap_8k = at_wrap(cnt8k_ff, SYNC8K_HALF_CYC);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt2k_ff <= '0;
      end else if (wrap_2k) begin
         cnt2k_ff <= '0;
      end else begin
         cnt2k_ff <= cnt2k_ff + 12'h001;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync_2k_ff <= 1'b0;
      end else if (wrap_2k) begin
         sync_2k_ff <= ~sync_2k_ff;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt8k_ff <= '0;
      end else if (wrap_8k) begin
         cnt8k_ff <= '0;
      end else begin
         cnt8k_ff <= cnt8k_ff + 12'h001;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync_8k_ff <= 1'b0;
      end else if (wrap_8k) begin
         sync_8k_ff <= ~sync_8k_ff;
      end
   end

   // ==========================================================
   // avalon slave, one wait state
   // ==========================================================
   logic ack_ff;
   logic [DATA_W-1:0] readdata_ff;
   logic [DATA_W-1:0] nxt_readdata;
   logic [CFG_W-1:0] cfg_ff;
   logic [DATA_W-1:0] status_word;
   logic req;
   logic wr_cfg;
   logic hit_cfg;
   logic hit_status;
   logic rd_first;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] offset);
      addr_hit = (a == offset);
   endfunction

   assign hit_cfg = addr_hit(bus_req.address, CFG_OFFSET);
   assign hit_status = addr_hit(bus_req.address, STATUS_OFFSET);
   assign req = bus_req.read | bus_req.write;
   // exactly one wait state; the write lands on the edge after it, which completes the access
   assign waitrequest = req & ~ack_ff;
   assign wr_cfg = bus_req.write & ack_ff & bus_req.byteenable[0] & hit_cfg;
   // read data is latched in the wait cycle, so it already stands when waitrequest drops
   assign rd_first = bus_req.read & ~ack_ff;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   always_comb begin
      status_word = '0;
      status_word[STAT_FIVE_ON] = |cfg_ff[FIVE_LSB +: SEL_W];
      status_word[STAT_SIX_ON] = |cfg_ff[SIX_LSB +: SEL_W];
      status_word[STAT_FIVE_LVL] = timing_output_five;
      status_word[STAT_SIX_LVL] = timing_output_six;
   end

   // unmapped addresses read as zero
   always_comb begin
      if (hit_cfg) begin
         nxt_readdata = DATA_W'(cfg_ff);
      end else if (hit_status) begin
         nxt_readdata = status_word;
      end else begin
         nxt_readdata = '0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         readdata_ff <= '0;
      end else if (rd_first) begin
         readdata_ff <= nxt_readdata;
      end
   end

   assign readdata = readdata_ff;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_ff <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg_ff <= bus_req.writedata[CFG_W-1:0];
      end
   end

   // ==========================================================
   // output selectors
   // ==========================================================
   // low nibble drives output five
   ocfs_out_sel u_five (
      .mclk(mclk),
      .rst_b(rst_b),
      .sel(cfg_ff[FIVE_LSB +: SEL_W]),
      .sync_2k(sync_2k_ff),
      .sync_8k(sync_8k_ff),
      .digital_rate_one(dig_sync_ff[1]),
      .main_edge(main_edge),
      .sec_edge(sec_edge),
      .clk_out(timing_output_five)
   );

   ocfs_out_sel u_six (
      .mclk(mclk),
      .rst_b(rst_b),
      .sel(cfg_ff[SIX_LSB +: SEL_W]),
      .sync_2k(sync_2k_ff),
      .sync_8k(sync_8k_ff),
      .digital_rate_one(dig_sync_ff[1]),
      .main_edge(main_edge),
      .sec_edge(sec_edge),
      .clk_out(timing_output_six)
   );

endmodule

/* File: test/ocfs_freq_select_props.sv */
`timescale 1ns/1ps
// ==========================================
// bus and output checks
// ==========================================
module ocfs_freq_select_props
   import ocfs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire ocfs_pkg::ocfs_bus_req_t bus_req,
   input wire logic [ocfs_pkg::DATA_W-1:0] readdata,
   input wire logic waitrequest,
   input wire logic main_output_analog_pll,
   input wire logic secondary_analog_pll,
   input wire logic digital_rate_one,
   input wire logic timing_output_five,
   input wire logic timing_output_six
);
   logic [7:0] cfg_ff;
   logic req;
   logic done;
   assign req = bus_req.read | bus_req.write;
   assign done = req & ~waitrequest;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // shadow copy; only low-byte writes to the config offset land
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         cfg_ff <= CFG_RESET;
      else if (done && bus_req.write && bus_req.address == CFG_OFFSET && bus_req.byteenable[0])
         cfg_ff <= bus_req.writedata[7:0];
   end
   a_wait_first: assert property ($rose(req) |-> waitrequest)
      else $error("request not stalled in first cycle");
   a_one_wait: assert property (req && waitrequest |=> !waitrequest)
      else $error("more than one wait state");
   a_idle_ready: assert property (!req |-> !waitrequest)
      else $error("wait raised while idle");
   a_cfg_readback: assert property (done && bus_req.read && bus_req.address == CFG_OFFSET |-> readdata == {24'h0, cfg_ff})
      else $error("config read mismatch");
   a_status_on: assert property (done && bus_req.read && bus_req.address == STATUS_OFFSET |->
      readdata[1:0] == {cfg_ff[7:4] != 4'h0, cfg_ff[3:0] != 4'h0})
      else $error("status enable bits wrong");
   a_unmapped_zero: assert property (done && bus_req.read && bus_req.address != CFG_OFFSET &&
      bus_req.address != STATUS_OFFSET |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   a_six_off: assert property ((cfg_ff[7:4] == 4'h0) [*3] |-> !timing_output_six)
      else $error("output six active while off");
   a_five_off: assert property ((cfg_ff[3:0] == 4'h0) [*3] |-> !timing_output_five)
      else $error("output five active while off");
   a_six_digital: assert property ((cfg_ff[7:4] == 4'h4) [*4] |->
      timing_output_six == $past(digital_rate_one, 3))
      else $error("output six not following digital rate");
   c_write: cover property (done && bus_req.write);
   c_six_runs: cover property ($rose(timing_output_six));
   c_five_runs: cover property ($rose(timing_output_five));
endmodule

bind ocfs_freq_select ocfs_freq_select_props u_props (.mclk(mclk), .rst_b(rst_b), .bus_req(bus_req),
   .readdata(readdata), .waitrequest(waitrequest), .main_output_analog_pll(main_output_analog_pll),
   .secondary_analog_pll(secondary_analog_pll), .digital_rate_one(digital_rate_one),
   .timing_output_five(timing_output_five), .timing_output_six(timing_output_six));

/* File: test/ocfs_freq_select_tb.sv */
`timescale 1ns/1ps
module ocfs_freq_select_tb;
   import ocfs_pkg::*;
   logic mclk;
   logic rst_b;
   ocfs_bus_req_t req = '0;
   logic [31:0] readdata;
   logic waitrequest;
   logic main_pll = 1'b0;
   logic sec_pll = 1'b0;
   logic dig = 1'b0;
   logic out5;
   logic out6;
   logic [31:0] q;
   int cyc = 0;
   int n_fail = 0;
   int total_checks = 0;

   ocfs_freq_select dut (.mclk(mclk), .rst_b(rst_b), .bus_req(req), .readdata(readdata),
      .waitrequest(waitrequest), .main_output_analog_pll(main_pll), .secondary_analog_pll(sec_pll),
      .digital_rate_one(dig), .timing_output_five(out5), .timing_output_six(out6));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // ==========================================
   // pll and digital rate stand-ins: half periods of 2, 3 and 5 cycles
   // ==========================================
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc % 2 == 1) main_pll <= ~main_pll;
      if (cyc % 3 == 2) sec_pll <= ~sec_pll;
      if (cyc % 5 == 4) dig <= ~dig;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one bus access; an idle edge first so release and raise never share a step
   task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge mclk);
      req.read <= !wr;
      req.write <= wr;
      req.address <= a;
      req.writedata <= {24'h0, d};
      req.byteenable <= be;
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0);
      q = readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      check(32'(n), 32'h2);
   endtask

   // third interval between toggles: a mux step and a restarted divider are skipped
   task automatic measure(input logic six, input int half);
      logic prev;
      int n;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         prev = six ? out6 : out5;
         while ((six ? out6 : out5) === prev && n < 6000) begin
            @(posedge mclk);
            n++;
         end
      end
      check(32'(n), 32'(half));
   endtask

   initial begin
      repeat (60000) @(posedge mclk);
      n_fail++;
      finish_test;
   end

   initial begin
      rst_b = 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      acc(1'b0, CFG_OFFSET, 8'h00, 4'hF);
      check(q, 32'h8A);
      acc(1'b0, STATUS_OFFSET, 8'h00, 4'hF);
      check(32'(q[1:0]), 32'h3);
      acc(1'b0, 4'hC, 8'h00, 4'hF);
      check(q, 32'h0);
      acc(1'b1, CFG_OFFSET, 8'h20, 4'h0);
      acc(1'b0, CFG_OFFSET, 8'h00, 4'hF);
      check(q, 32'h8A);
      acc(1'b1, CFG_OFFSET, 8'h00, 4'h1);
      repeat (50) @(posedge mclk);
      check(32'({out6, out5}), 32'h0);
      acc(1'b0, STATUS_OFFSET, 8'h00, 4'hF);
      check(q, 32'h0);
      acc(1'b1, CFG_OFFSET, 8'h21, 4'h1);
      measure(1'b1, 625);
      measure(1'b0, 2500);
      acc(1'b1, CFG_OFFSET, 8'h8F, 4'h1);
      measure(1'b1, 16);
      measure(1'b0, 12);
      acc(1'b1, CFG_OFFSET, 8'h8E, 4'h1);
      measure(1'b1, 16);
      measure(1'b0, 24);
      acc(1'b1, CFG_OFFSET, 8'h4B, 4'h1);
      measure(1'b1, 5);
      measure(1'b0, 144);
      acc(1'b1, CFG_OFFSET, 8'h53, 4'h1);
      measure(1'b1, 96);
      measure(1'b0, 4);
      acc(1'b1, CFG_OFFSET, 8'h79, 4'h1);
      measure(1'b1, 24);
      measure(1'b0, 12);
      acc(1'b1, CFG_OFFSET, 8'hDC, 4'h1);
      measure(1'b1, 36);
      measure(1'b0, 48);
      acc(1'b1, CFG_OFFSET, 8'h6A, 4'h1);
      measure(1'b1, 32);
      measure(1'b0, 8);
      // reset in mid-run brings back the default codes
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      acc(1'b0, CFG_OFFSET, 8'h00, 4'hF);
      check(q, 32'h8A);
      finish_test;
   end
endmodule
